// ---- src/brc_consts.svh ----
`ifndef BRC_CONSTS_SVH
`define BRC_CONSTS_SVH

// -----------------------------------------------------------------
// Register offsets (byte addresses, one word each).
// -----------------------------------------------------------------
`define BRC_ADDR_CFG        8'h00
`define BRC_ADDR_TRIP_SEAL  8'h04
`define BRC_ADDR_CLOSE_SEAL 8'h08
`define BRC_ADDR_BRK_OP     8'h0C
`define BRC_ADDR_BF         8'h10
`define BRC_ADDR_AUX_CFG    8'h14
`define BRC_ADDR_CMD        8'h18
`define BRC_ADDR_STATUS     8'h1C
`define BRC_ADDR_DWELL0     8'h20
`define BRC_ADDR_DWELL4     8'h30

// -----------------------------------------------------------------
// Field positions and codes.
// -----------------------------------------------------------------
`define BRC_CFG_CLOSED_BIT  0
`define BRC_CFG_OPEN_BIT    1
`define BRC_CFG_BF_EN_BIT   2
`define BRC_CFG_BRKOP_BIT   3
`define BRC_AUX_LATCH       2'h0
`define BRC_AUX_SELF        2'h1
`define BRC_AUX_PULSE       2'h2

// -----------------------------------------------------------------
// Reset values and timing.
// -----------------------------------------------------------------
`define BRC_CFG_RESET       4'h0
`define BRC_AUX_CFG_RESET   20'h0_0000
`define BRC_DWELL_RESET     16'h0064
`define BRC_TICK_NS         32'h000F_4240
`define BRC_CLK_NS          32'h0000_0005
`define BRC_MS_PER_S        16'h03E8
`define BRC_DEF_BRK_OP_S    16'h0002
`define BRC_DEF_BRK_OP_MS   (`BRC_DEF_BRK_OP_S * `BRC_MS_PER_S)
`define BRC_DEF_BF_MS       16'h0064
`define BRC_CLOSE_FIXED_MS  16'h00C8
`define BRC_SEAL_STEP_MS    16'h000A
`define BRC_SEAL_DEF_MS     16'h0028
`define BRC_SEAL_RESET      10'(`BRC_SEAL_DEF_MS / `BRC_SEAL_STEP_MS)
`define BRC_SEAL_MAX        10'h3E7

`endif

// ---- src/brc_pkg.sv ----
package brc_pkg;

    // States of a trip or close output channel.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HOLD,
        ST_SEAL
    } brc_state_t;

endpackage

// ---- src/brc_relay_ctrl.sv ----
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "brc_consts.svh"
// Behaviour
// - Eight outputs: trip, close, warning, auxiliaries three to seven.
// - Trip, close and warning are fixed; auxiliaries set by software.
// - Trip or close holds until breaker state confirmed and request gone.
// - Unchanged breaker: release after operation delay, else after 2 s.
// - No contacts assigned: trip releases after failure delay or 100 ms.
// - No contacts assigned: close operates for 200 ms then releases.
// - Seal-in time extends trip and close release; default 40 ms.
// - Open contact assigned: trip released when it reports breaker open.
// - Only closed contact assigned: trip released when it reports open.
// - Closed contact assigned: close released when it reports closed.
// - Only open contact assigned: close released when it reports closed.
// - Auxiliary: energized or not, latched, self-resetting or pulsed.
// - Latched auxiliary holds until key, input or remote reset.
// - Self-resetting auxiliary follows its request.
// - Pulsed auxiliary runs dwell timer from first request.
// - Seal-in spans 0 to 9.99 s in 10 ms steps.
module brc_relay_ctrl #(
    parameter int CLK_PER_MS = `BRC_TICK_NS / `BRC_CLK_NS
) (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        trip_request,
    input  wire logic        close_request,
    input  wire logic [4:0]  aux_request,
    input  wire logic        selftest_fail,
    input  wire logic        breaker_closed_aux_contact,
    input  wire logic        breaker_open_aux_contact,
    input  wire logic        reset_key,
    input  wire logic        reset_input,
    output logic      [7:0]  relay_coil
);

    localparam int DW = $clog2(CLK_PER_MS);

    // ---------------------------------------------------------------
    // Reset release and pin synchronisers
    // ---------------------------------------------------------------
    logic          rst_meta_q;
    logic          rst_n;
    logic [3:0]    pin_meta_q;
    logic [3:0]    pin_q;
    logic          closed_s;
    logic          open_s;
    logic          reset_any;
    logic [1:0]    req_prev_q;
    logic [1:0]    ch_req;

    // Every assertion in this module shares this clock and reset.
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Reset is released through two flops; pins pass two flops.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q <= 4'h0;
            pin_q      <= 4'h0;
        end else begin
            pin_meta_q <= {reset_input, reset_key,
                           breaker_open_aux_contact,
                           breaker_closed_aux_contact};
            pin_q      <= pin_meta_q;
        end
    end

    assign closed_s = pin_q[0];
    assign open_s   = pin_q[1];
    assign ch_req   = {close_request, trip_request};

    // ---------------------------------------------------------------
    // Millisecond tick
    // ---------------------------------------------------------------
    logic [DW-1:0] div_q;
    logic [DW-1:0] div_d;
    logic          tick_q;
    logic          tick_d;

    // Free-running divider gives one pulse per millisecond.
    always_comb begin
        tick_d = (div_q == DW'(CLK_PER_MS - 1));
        div_d  = tick_d ? '0 : DW'(div_q + 1'b1);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_q      <= '0;
            tick_q     <= 1'b0;
            req_prev_q <= 2'h0;
        end else begin
            div_q      <= div_d;
            tick_q     <= tick_d;
            req_prev_q <= ch_req;
        end
    end

    // ---------------------------------------------------------------
    // Register file
    // ---------------------------------------------------------------
    logic [3:0]  cfg_q, cfg_d;
    logic [9:0]  tseal_q, tseal_d, cseal_q, cseal_d;
    logic [15:0] brkop_q, brkop_d, bf_q, bf_d;
    logic [19:0] auxcfg_q, auxcfg_d;
    logic [15:0] dwell_q [5];
    logic [15:0] dwell_d [5];
    logic        rrst_q, rrst_d;
    logic [31:0] rdata_d;
    logic        open_asg, closed_asg, any_asg;

    // Clamp a seal-in write to the largest legal step count.
    function automatic logic [9:0] seal_clip(input logic [31:0] v);
        seal_clip = (v > 32'(`BRC_SEAL_MAX)) ? `BRC_SEAL_MAX : v[9:0];
    endfunction

    // Decodes writes, the remote reset pulse and the read answer.
    always_comb begin
        cfg_d    = cfg_q;
        tseal_d  = tseal_q;
        cseal_d  = cseal_q;
        brkop_d  = brkop_q;
        bf_d     = bf_q;
        auxcfg_d = auxcfg_q;
        dwell_d  = dwell_q;
        rrst_d   = reg_wr && (reg_addr == `BRC_ADDR_CMD) && reg_wdata[0];
        rdata_d  = 32'h0000_0000;
        if (reg_wr) begin
            unique case (reg_addr)
                `BRC_ADDR_CFG:        cfg_d    = reg_wdata[3:0];
                `BRC_ADDR_TRIP_SEAL:  tseal_d  = seal_clip(reg_wdata);
                `BRC_ADDR_CLOSE_SEAL: cseal_d  = seal_clip(reg_wdata);
                `BRC_ADDR_BRK_OP:     brkop_d  = reg_wdata[15:0];
                `BRC_ADDR_BF:         bf_d     = reg_wdata[15:0];
                `BRC_ADDR_AUX_CFG:    auxcfg_d = reg_wdata[19:0];
                default: begin
                    for (int i = 0; i < 5; i++) begin
                        if (reg_addr == 8'(`BRC_ADDR_DWELL0 + 4 * i)) begin
                            dwell_d[i] = reg_wdata[15:0];
                        end
                    end
                end
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `BRC_ADDR_CFG:        rdata_d = {28'h000_0000, cfg_q};
                `BRC_ADDR_TRIP_SEAL:  rdata_d = {22'h00_0000, tseal_q};
                `BRC_ADDR_CLOSE_SEAL: rdata_d = {22'h00_0000, cseal_q};
                `BRC_ADDR_BRK_OP:     rdata_d = {16'h0000, brkop_q};
                `BRC_ADDR_BF:         rdata_d = {16'h0000, bf_q};
                `BRC_ADDR_AUX_CFG:    rdata_d = {12'h000, auxcfg_q};
                `BRC_ADDR_STATUS:
                    rdata_d = {22'h00_0000, open_s, closed_s, relay_coil};
                default: begin
                    for (int i = 0; i < 5; i++) begin
                        if (reg_addr == 8'(`BRC_ADDR_DWELL0 + 4 * i)) begin
                            rdata_d = {16'h0000, dwell_q[i]};
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q     <= `BRC_CFG_RESET;
            tseal_q   <= `BRC_SEAL_RESET;
            cseal_q   <= `BRC_SEAL_RESET;
            brkop_q   <= 16'h0000;
            bf_q      <= 16'h0000;
            auxcfg_q  <= `BRC_AUX_CFG_RESET;
            dwell_q   <= '{default: `BRC_DWELL_RESET};
            rrst_q    <= 1'b0;
            reg_rdata <= 32'h0000_0000;
        end else begin
            cfg_q     <= cfg_d;
            tseal_q   <= tseal_d;
            cseal_q   <= cseal_d;
            brkop_q   <= brkop_d;
            bf_q      <= bf_d;
            auxcfg_q  <= auxcfg_d;
            dwell_q   <= dwell_d;
            rrst_q    <= rrst_d;
            reg_rdata <= rdata_d;
        end
    end

    assign closed_asg = cfg_q[`BRC_CFG_CLOSED_BIT];
    assign open_asg   = cfg_q[`BRC_CFG_OPEN_BIT];
    assign any_asg    = open_asg | closed_asg;
    assign reset_any  = rrst_q | pin_q[2] | pin_q[3];

    // ---------------------------------------------------------------
    // Trip (0) and close (1) channels
    // ---------------------------------------------------------------
    logic [1:0] conf;

    // Breaker state that ends each request, per assigned contacts.
    assign conf[0] = open_asg ? open_s
                   : (closed_asg & ~closed_s);
    assign conf[1] = closed_asg ? closed_s
                   : (open_asg & ~open_s);

    for (genvar gi = 0; gi < 2; gi++) begin : ch
        brc_pkg::brc_state_t st_q, st_d;
        logic [15:0]         cnt_q, cnt_d, lim, seal_lim;
        logic                free;
        logic                req;

        assign req  = ch_req[gi];
        assign free = (gi == 1) && !any_asg;

        // Release limit of the hold phase and the seal-in length.
        always_comb begin
            if (any_asg) begin
                lim = cfg_q[`BRC_CFG_BRKOP_BIT] ? brkop_q
                    : 16'(`BRC_DEF_BRK_OP_MS);
            end else if (gi == 0) begin
                lim = cfg_q[`BRC_CFG_BF_EN_BIT] ? bf_q
                    : `BRC_DEF_BF_MS;
            end else begin
                lim = `BRC_CLOSE_FIXED_MS;
            end
            seal_lim = 16'(16'((gi == 0) ? tseal_q : cseal_q)
                     * `BRC_SEAL_STEP_MS);
        end

        // Operate, hold, then seal-in before release.
        always_comb begin
            st_d  = st_q;
            cnt_d = cnt_q;
            unique case (st_q)
                brc_pkg::ST_IDLE: begin
                    if (req && !req_prev_q[gi]) begin
                        st_d  = brc_pkg::ST_HOLD;
                        cnt_d = 16'h0000;
                    end
                end
                brc_pkg::ST_HOLD: begin
                    if (any_asg && conf[gi] && !req) begin
                        st_d  = brc_pkg::ST_SEAL;
                        cnt_d = 16'h0000;
                    end else if (req && !free) begin
                        cnt_d = 16'h0000;
                    end else if (cnt_q >= lim) begin
                        st_d  = brc_pkg::ST_SEAL;
                        cnt_d = 16'h0000;
                    end else if (tick_q) begin
                        cnt_d = 16'(cnt_q + 1'b1);
                    end
                end
                brc_pkg::ST_SEAL: begin
                    if (req && !free) begin
                        st_d  = brc_pkg::ST_HOLD;
                        cnt_d = 16'h0000;
                    end else if (cnt_q >= seal_lim) begin
                        st_d  = brc_pkg::ST_IDLE;
                    end else if (tick_q) begin
                        cnt_d = 16'(cnt_q + 1'b1);
                    end
                end
            endcase
        end

        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                st_q  <= brc_pkg::ST_IDLE;
                cnt_q <= 16'h0000;
            end else begin
                st_q  <= st_d;
                cnt_q <= cnt_d;
            end
        end
    end

    // ---------------------------------------------------------------
    // Auxiliary channels three to seven
    // ---------------------------------------------------------------
    for (genvar ai = 0; ai < 5; ai++) begin : aux
        logic [1:0]  mode;
        logic        op_q, op_d, prev_q;
        logic [15:0] dw_q, dw_d;

        assign mode = auxcfg_q[4 * ai +: 2];

        // Mode-dependent operate logic; set wins over reset.
        always_comb begin
            op_d = op_q;
            dw_d = dw_q;
            case (mode)
                `BRC_AUX_LATCH: begin
                    if (aux_request[ai]) begin
                        op_d = 1'b1;
                    end else if (reset_any) begin
                        op_d = 1'b0;
                    end
                end
                `BRC_AUX_SELF: op_d = aux_request[ai];
                `BRC_AUX_PULSE: begin
                    if (!op_q && aux_request[ai] && !prev_q) begin
                        op_d = 1'b1;
                        dw_d = 16'h0000;
                    end else if (op_q && dw_q >= dwell_q[ai]) begin
                        op_d = 1'b0;
                    end else if (op_q && tick_q) begin
                        dw_d = 16'(dw_q + 1'b1);
                    end
                end
                default: op_d = 1'b0;
            endcase
        end

        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                op_q   <= 1'b0;
                dw_q   <= 16'h0000;
                prev_q <= 1'b0;
            end else begin
                op_q   <= op_d;
                dw_q   <= dw_d;
                prev_q <= aux_request[ai];
            end
        end
    end

    // ---------------------------------------------------------------
    // Coil outputs
    // ---------------------------------------------------------------
    logic [7:0] coil_d;

    // Trip and close from their state; auxiliaries through polarity; warning from self-test.
    always_comb begin
        coil_d[0] = (ch[0].st_d != brc_pkg::ST_IDLE);
        coil_d[1] = (ch[1].st_d != brc_pkg::ST_IDLE);
        coil_d[2] = aux[0].op_d ^ auxcfg_q[2];
        coil_d[3] = aux[1].op_d ^ auxcfg_q[6];
        coil_d[4] = aux[2].op_d ^ auxcfg_q[10];
        coil_d[5] = aux[3].op_d ^ auxcfg_q[14];
        coil_d[6] = aux[4].op_d ^ auxcfg_q[18];
        coil_d[7] = !selftest_fail;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            relay_coil <= 8'h00;
        end else begin
            relay_coil <= coil_d;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    chk_trip_hold_req: assert property (
        ch[0].st_q == brc_pkg::ST_HOLD && trip_request
        |=> ch[0].st_q == brc_pkg::ST_HOLD && relay_coil[0])
        else $error("trip released while requested");
    chk_trip_open_rel: assert property (
        open_asg && open_s && !trip_request
        && ch[0].st_q == brc_pkg::ST_HOLD |=> ch[0].st_q == brc_pkg::ST_SEAL)
        else $error("trip not released by open contact");
    chk_trip_closed_rel: assert property (
        !open_asg && closed_asg && !closed_s && !trip_request
        && ch[0].st_q == brc_pkg::ST_HOLD |=> ch[0].st_q == brc_pkg::ST_SEAL)
        else $error("trip not released by closed contact");
    chk_close_closed_rel: assert property (
        closed_asg && closed_s && !close_request
        && ch[1].st_q == brc_pkg::ST_HOLD |=> ch[1].st_q == brc_pkg::ST_SEAL)
        else $error("close not released by closed contact");
    chk_close_open_rel: assert property (
        !closed_asg && open_asg && !open_s && !close_request
        && ch[1].st_q == brc_pkg::ST_HOLD |=> ch[1].st_q == brc_pkg::ST_SEAL)
        else $error("close not released by open contact");
    chk_close_fixed_time: assert property (
        !any_asg && ch[1].st_q == brc_pkg::ST_HOLD
        && ch[1].cnt_q == `BRC_CLOSE_FIXED_MS
        |=> ch[1].st_q == brc_pkg::ST_SEAL)
        else $error("close fixed pulse not ended at 200 ms");
    chk_trip_default_time: assert property (
        !any_asg && !cfg_q[`BRC_CFG_BF_EN_BIT] && !trip_request
        && ch[0].st_q == brc_pkg::ST_HOLD && ch[0].cnt_q == `BRC_DEF_BF_MS
        |=> ch[0].st_q == brc_pkg::ST_SEAL)
        else $error("trip default 100 ms release missed");
    chk_close_brkop_time: assert property (
        any_asg && !conf[1] && !cfg_q[`BRC_CFG_BRKOP_BIT] && !close_request
        && ch[1].st_q == brc_pkg::ST_HOLD
        && ch[1].cnt_q == 16'(`BRC_DEF_BRK_OP_MS)
        |=> ch[1].st_q == brc_pkg::ST_SEAL)
        else $error("close 2 s fallback release missed");
    chk_seal_zero_rel: assert property (
        tseal_q == 10'h000 && !trip_request
        && ch[0].st_q == brc_pkg::ST_SEAL
        |=> ch[0].st_q == brc_pkg::ST_IDLE && !relay_coil[0])
        else $error("zero seal-in did not release trip");
    chk_latch_hold: assert property (
        aux[1].mode == `BRC_AUX_LATCH && aux[1].op_q && !reset_any
        |=> aux[1].op_q)
        else $error("latched output dropped without reset");
    chk_self_follow: assert property (
        aux[0].mode == `BRC_AUX_SELF
        |=> aux[0].op_q == $past(aux_request[0]))
        else $error("self-resetting output does not follow request");
    chk_tick_single: assert property (
        tick_q |=> !tick_q)
        else $error("millisecond tick longer than one cycle");

endmodule

// ---- verif/brc_breaker_model.sv ----
`timescale 1ns/10ps
// -----------------------------------------------------------------
// Breaker with two auxiliary contacts, driven by the coil outputs.
// -----------------------------------------------------------------
module brc_breaker_model #(
    parameter int OP_CYCLES = 20
) (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic trip_coil,
    input  wire logic close_coil,
    input  wire logic stuck,
    output logic      breaker_closed_aux_contact,
    output logic      breaker_open_aux_contact
);
    logic       closed_q;
    logic [7:0] cnt_q;
    logic       moving;

    // A stuck breaker ignores its coils, as a failed mechanism would.
    assign moving = !stuck && ((trip_coil && closed_q) ||
                               (close_coil && !closed_q));

    // The breaker starts closed and moves after the operating time.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            closed_q <= 1'b1;
            cnt_q    <= 8'h00;
        end else if (!moving) begin
            cnt_q <= 8'h00;
        end else if (cnt_q == 8'(OP_CYCLES - 1)) begin
            closed_q <= !closed_q;
            cnt_q    <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // Both contacts always report, one the inverse of the other.
    assign breaker_closed_aux_contact = closed_q;
    assign breaker_open_aux_contact   = !closed_q;
endmodule

// ---- verif/breaker_output_relay_control_tb.sv ----
`timescale 1ns/10ps
`include "brc_consts.svh"
module breaker_output_relay_control_tb;
    localparam int CPM  = 4;
    localparam int SEAL = `BRC_SEAL_DEF_MS * CPM;
    logic        clock;
    logic        reset_n;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [1:0]  tc_req;
    logic [4:0]  aux_req;
    logic        selftest_fail;
    logic        closed_ct;
    logic        open_ct;
    logic        reset_key;
    logic        reset_input;
    logic        stuck;
    logic [7:0]  relay_coil;
    int          n_mismatch;
    int          tests_run;

    brc_relay_ctrl #(.CLK_PER_MS(CPM)) DUT (
        .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .trip_request(tc_req[0]),
        .close_request(tc_req[1]), .aux_request(aux_req),
        .selftest_fail(selftest_fail),
        .breaker_closed_aux_contact(closed_ct),
        .breaker_open_aux_contact(open_ct), .reset_key(reset_key),
        .reset_input(reset_input), .relay_coil(relay_coil));

    brc_breaker_model brk (
        .clock(clock), .reset_n(reset_n), .trip_coil(relay_coil[0]),
        .close_coil(relay_coil[1]), .stuck(stuck),
        .breaker_closed_aux_contact(closed_ct),
        .breaker_open_aux_contact(open_ct));

    // -----------------------------------------------------------------
    // Checking and bus tasks.
    // -----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        tests_run++;
        if (got !== ex) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic chk_span(input string nm, input int lo, input int hi,
                            input int got);
        tests_run++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ex,
                      input string nm);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(nm, ex, reg_rdata);
        @(posedge clock);
    endtask

    // Raises a trip (b=0) or close (b=1) request for h + 1 cycles and
    // counts the cycles for which the matching coil stays energised.
    task automatic pulse(input int b, input logic [31:0] cfg,
                         input logic stk, input int h, input int ex);
        int n;
        n = 0;
        wr(`BRC_ADDR_CFG, cfg);
        stuck     <= stk;
        tc_req[b] <= 1'b1;
        for (int i = 0; i < 20000 && (i <= h || relay_coil[b]); i++) begin
            @(posedge clock);
            #1;
            if (i == h) tc_req[b] <= 1'b0;
            if (relay_coil[b] === 1'b1) n++;
        end
        chk_span(b ? "close coil" : "trip coil", ex - 2 * CPM - 4,
                 ex + CPM + 4, n);
        repeat (4) @(posedge clock);
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Free-running 200 MHz clock.
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Cuts a hung run short.
    initial begin
        repeat (60000) @(posedge clock);
        n_mismatch++;
        $display("ERROR watchdog expected end seen hang");
        give_verdict;
    end

    // -----------------------------------------------------------------
    // Test sequence.
    // -----------------------------------------------------------------
    initial begin
        {reset_n, reg_addr, reg_wdata, reg_wr, reg_rd, tc_req} = '0;
        {aux_req, selftest_fail, reset_key, reset_input, stuck} = '0;
        n_mismatch = 0;
        tests_run  = 0;
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        #1 chk("coil after reset", 32'h0000_0080, relay_coil);
        rd(`BRC_ADDR_CFG, 32'h0000_0000, "cfg");
        rd(`BRC_ADDR_TRIP_SEAL, 32'h0000_0004, "trip seal");
        rd(`BRC_ADDR_CLOSE_SEAL, 32'h0000_0004, "close seal");
        rd(`BRC_ADDR_DWELL0, 32'h0000_0064, "dwell");
        rd(8'h40, 32'h0000_0000, "unmapped");
        rd(`BRC_ADDR_STATUS, 32'h0000_0180, "status");
        wr(`BRC_ADDR_TRIP_SEAL, 32'h0000_03FF);
        rd(`BRC_ADDR_TRIP_SEAL, 32'h0000_03E7, "seal clamp");
        wr(`BRC_ADDR_TRIP_SEAL, 32'h0000_0004);
        $display("register test done");

        for (int c = 0; c < 3; c++) begin
            pulse(0, 32'(3 - c), 1'b0, 8, 24 + SEAL);
            pulse(1, 32'(3 - c), 1'b0, 8, 24 + SEAL);
        end
        pulse(0, 32'h0000_0003, 1'b0, 60, 62 + SEAL);
        wr(`BRC_ADDR_TRIP_SEAL, 32'h0000_0000);
        pulse(0, 32'h0000_0003, 1'b0, 8, 10);
        wr(`BRC_ADDR_TRIP_SEAL, 32'h0000_0004);
        $display("contact release test done");

        wr(`BRC_ADDR_BRK_OP, 32'h0000_0032);
        wr(`BRC_ADDR_BF, 32'h0000_001E);
        pulse(1, 32'h0000_0003, 1'b1, 8,
              10 + `BRC_DEF_BRK_OP_MS * CPM + SEAL);
        pulse(1, 32'h0000_000B, 1'b1, 8, 10 + 50 * CPM + SEAL);
        pulse(0, 32'h0000_0000, 1'b1, 8, 10 + 100 * CPM + SEAL);
        pulse(0, 32'h0000_0004, 1'b1, 8, 10 + 30 * CPM + SEAL);
        pulse(1, 32'h0000_0000, 1'b1, 8, 1 + 200 * CPM + SEAL);
        $display("timeout release test done");

        wr(`BRC_ADDR_AUX_CFG, 32'h0005_3201);
        wr(8'h28, 32'h0000_000A);
        aux_req <= 5'h1F;
        repeat (2) @(posedge clock);
        #1 chk("aux operated", 5'h07, relay_coil[6:2]);
        aux_req <= 5'h00;
        repeat (2) @(posedge clock);
        #1 chk("aux released", 5'h16, relay_coil[6:2]);
        repeat (60) @(posedge clock);
        #1 chk("aux dwell end", 5'h12, relay_coil[6:2]);
        for (int m = 0; m < 3; m++) begin
            aux_req <= 5'h02;
            @(posedge clock);
            aux_req <= 5'h00;
            repeat (2) @(posedge clock);
            #1 chk("aux latched", 5'h12, relay_coil[6:2]);
            if (m == 2) begin
                wr(`BRC_ADDR_CMD, 32'h0000_0001);
            end else begin
                reset_key   <= (m == 0);
                reset_input <= (m == 1);
                repeat (2) @(posedge clock);
                reset_key   <= 1'b0;
                reset_input <= 1'b0;
            end
            repeat (4) @(posedge clock);
            #1 chk("aux cleared", 5'h10, relay_coil[6:2]);
        end
        $display("auxiliary test done");

        selftest_fail <= 1'b1;
        repeat (2) @(posedge clock);
        #1 chk("warning fault", 1'b0, relay_coil[7]);
        selftest_fail <= 1'b0;
        repeat (2) @(posedge clock);
        #1 chk("warning ok", 1'b1, relay_coil[7]);
        $display("warning test done");
        give_verdict;
    end
endmodule
